// file: rtl/pvi_irq_unit.sv
// Prioritized vectored interrupt unit: registers, sensing, arbitration, vectoring
`timescale 1ns/1ps

module pvi_irq_unit
  import pvi_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [7:0]  sfrAddr,
  input  wire logic        sfrWrEn,
  input  wire logic [7:0]  sfrWrData,
  input  wire logic        sfrRdEn,
  output logic      [7:0]  sfrRdData,
  output logic             sfrHit,
  // Sense mode of the two active-low sources (1: falling edge, 0: low level)
  input  wire logic        pin3EdgeSel,
  input  wire logic        cipherEdgeSel,
  // Request sources
  input  wire logic        port0_pin3,
  input  wire logic        timer0_overflow_req,
  input  wire logic        cipher_ready_req,
  input  wire logic        timer1_overflow_req,
  input  wire logic        serial_receive_req,
  input  wire logic        serial_transmit_req,
  input  wire logic        timer2_overflow_req,
  input  wire logic        timer2_external_event_req,
  input  wire logic        radio_spi_ready_req,
  input  wire logic        radio_event_req,
  input  wire logic        spi_master_complete_req,
  input  wire logic        spi_slave_complete_req,
  input  wire logic        usb_resume_req,
  input  wire logic        usb_event_req,
  input  wire logic        internal_wakeup_req,
  // Core side
  output logic             irqReq,
  output logic      [15:0] irqVector,
  input  wire logic        irqAck,
  input  wire logic        irqRetAck
);

  // Register state
  logic [7:0]  spiSelFf, enPriFf, prioLoFf, enSecFf, prioHiFf, flagsFf;
  logic [7:0]  rdDataFf;
  logic [7:0]  prevFf;
  logic        pin3FlagFf, cipherFlagFf;
  logic [3:0]  inServiceFf;
  logic        reqFf;
  logic [3:0]  idxFf;
  logic [1:0]  lvlFf;
  logic [15:0] vecFf;

  // Address decode
  wire wrSpiSel = sfrWrEn && (sfrAddr == ADDR_SPI_SEL);
  wire wrEnPri  = sfrWrEn && (sfrAddr == ADDR_EN_PRI);
  wire wrPrioLo = sfrWrEn && (sfrAddr == ADDR_PRIO_LO);
  wire wrEnSec  = sfrWrEn && (sfrAddr == ADDR_EN_SEC);
  wire wrPrioHi = sfrWrEn && (sfrAddr == ADDR_PRIO_HI);
  wire wrFlags  = sfrWrEn && (sfrAddr == ADDR_REQ_FLAGS);
  assign sfrHit = (sfrAddr == ADDR_SPI_SEL) || (sfrAddr == ADDR_EN_PRI) ||
                  (sfrAddr == ADDR_PRIO_LO) || (sfrAddr == ADDR_EN_SEC) ||
                  (sfrAddr == ADDR_PRIO_HI) || (sfrAddr == ADDR_REQ_FLAGS);

  // Read mux; unmapped addresses read as zero
  logic [7:0] rdMux;
  always_comb begin
    case (sfrAddr)
      ADDR_SPI_SEL:   rdMux = spiSelFf;
      ADDR_EN_PRI:    rdMux = enPriFf;
      ADDR_PRIO_LO:   rdMux = prioLoFf;
      ADDR_EN_SEC:    rdMux = enSecFf;
      ADDR_PRIO_HI:   rdMux = prioHiFf;
      ADDR_REQ_FLAGS: rdMux = flagsFf;
      default:        rdMux = 8'h00;
    endcase
  end

  // Edge detection on the previous sample of each edge-sensed input
  wire [7:0] curIn = {internal_wakeup_req, usb_event_req, usb_resume_req,
                      spi_slave_complete_req, spi_master_complete_req,
                      radio_event_req, cipher_ready_req, port0_pin3};
  wire pin3Fall   = prevFf[0] && !port0_pin3;
  wire cipherFall = prevFf[1] && !cipher_ready_req;
  wire radioEdge  = prevFf[2] ^ radio_event_req;
  wire masterEdge = prevFf[3] ^ spi_master_complete_req;
  wire slaveEdge  = prevFf[4] ^ spi_slave_complete_req;
  wire usbResRise = !prevFf[5] && usb_resume_req;
  wire usbRise    = !prevFf[6] && usb_event_req;
  wire wakeRise   = !prevFf[7] && internal_wakeup_req;

  // Flag set events; enables play no part here, so wakeups always mark
  logic [7:0] flagSet;
  assign flagSet[FLG_T2_EXT]     = timer2_external_event_req;
  assign flagSet[FLG_T2_OVF]     = timer2_overflow_req;
  assign flagSet[FLG_WAKE]       = wakeRise;
  assign flagSet[FLG_USB]        = usbRise;
  assign flagSet[FLG_USB_RESUME] = usbResRise;
  assign flagSet[FLG_SPI_DONE]   = (masterEdge && spiSelFf[BIT_SPI_MASTER]) ||
                                   (slaveEdge && spiSelFf[BIT_SPI_SLAVE]);
  assign flagSet[FLG_RADIO]      = radioEdge;
  assign flagSet[FLG_RADIO_SPI]  = radio_spi_ready_req;

  // A vectoring acknowledge counts only while a request stands
  wire ackTaken = irqAck && reqFf;

  // Hardware clear on vectoring for the four auto-clear flags only
  logic [7:0] autoClr;
  assign autoClr = {2'b00,
                    ackTaken && (idxFf == SRC_WAKE),
                    ackTaken && (idxFf == SRC_USB),
                    ackTaken && (idxFf == SRC_USB_RESUME),
                    1'b0,
                    ackTaken && (idxFf == SRC_RADIO),
                    1'b0};

  // Set wins over both the software write and the auto clear
  wire [7:0] nxt_flags = (wrFlags ? sfrWrData : (flagsFf & ~autoClr)) | flagSet;

  // Internal edge latches of the active-low sources, cleared on vectoring
  wire nxt_pin3Flag   = (pin3EdgeSel && pin3Fall) ||
                        (pin3FlagFf && !(ackTaken && idxFf == SRC_PIN3));
  wire nxt_cipherFlag = (cipherEdgeSel && cipherFall) ||
                        (cipherFlagFf && !(ackTaken && idxFf == SRC_CIPHER));

  // Pending and enable per arbitration slot
  logic [NUM_SRC-1:0] srcPend, srcEn;
  assign srcPend[SRC_PIN3]   = pin3EdgeSel ? pin3FlagFf : !port0_pin3;
  assign srcPend[SRC_TIMER0] = timer0_overflow_req;
  assign srcPend[SRC_CIPHER] = cipherEdgeSel ? cipherFlagFf : !cipher_ready_req;
  assign srcPend[SRC_TIMER1] = timer1_overflow_req;
  assign srcPend[SRC_SERIAL] = serial_receive_req || serial_transmit_req;
  assign srcPend[SRC_TIMER2] = (flagsFf[FLG_T2_OVF] && enPriFf[5]) ||
                               (flagsFf[FLG_T2_EXT] && enSecFf[7]);
  assign srcPend[SRC_RADIO_SPI]  = flagsFf[FLG_RADIO_SPI];
  assign srcPend[SRC_RADIO]      = flagsFf[FLG_RADIO];
  assign srcPend[SRC_SPI_DONE]   = flagsFf[FLG_SPI_DONE];
  assign srcPend[SRC_USB_RESUME] = flagsFf[FLG_USB_RESUME];
  assign srcPend[SRC_USB]        = flagsFf[FLG_USB];
  assign srcPend[SRC_WAKE]       = flagsFf[FLG_WAKE];
  assign srcEn = {enSecFf[5], enSecFf[4], enSecFf[3], enSecFf[2], enSecFf[1],
                  enSecFf[0], 1'b1, enPriFf[4], enPriFf[3], enPriFf[2],
                  enPriFf[1], enPriFf[0]};

  // Level of each slot: group is slot modulo six, high bit from the high register
  logic [1:0] srcLevel [NUM_SRC];
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_lvl
    localparam int GRP = i % NUM_GRP;
    assign srcLevel[i] = {prioHiFf[GRP], prioLoFf[GRP]};
  end

  // Highest level wins; descending scan with >= leaves the lowest vector on ties
  logic       winValid;
  logic [3:0] winIdx;
  logic [1:0] winLvl;
  always_comb begin
    winValid = 1'b0;
    winIdx   = 4'h0;
    winLvl   = 2'b00;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (srcPend[k] && srcEn[k] && (!winValid || srcLevel[k] >= winLvl)) begin
        winValid = 1'b1;
        winIdx   = 4'(k);
        winLvl   = srcLevel[k];
      end
    end
  end

  // Highest level now in service
  wire       topValid = |inServiceFf;
  wire [1:0] topLvl   = inServiceFf[3] ? 2'd3 : inServiceFf[2] ? 2'd2 :
                        inServiceFf[1] ? 2'd1 : 2'd0;
  wire [3:0] topOneHot = topValid ? (4'h1 << topLvl) : 4'h0;

  // Offer a request only above the running level; drop it in the ack cycle
  wire take = enPriFf[BIT_GLOBAL_EN] && winValid &&
              (!topValid || winLvl > topLvl) && !ackTaken;

  // Return ends the top routine before a same-cycle ack opens the next one
  wire [3:0] nxt_inService = (inServiceFf & ~(irqRetAck ? topOneHot : 4'h0)) |
                             (ackTaken ? (4'h1 << lvlFf) : 4'h0);

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      spiSelFf <= RST_SPI_SEL;
      enPriFf  <= RST_EN_PRI;
      prioLoFf <= RST_PRIO;
      enSecFf  <= RST_EN_SEC;
      prioHiFf <= RST_PRIO;
    end else begin
      if (wrSpiSel) spiSelFf <= sfrWrData & MASK_SPI_SEL;
      if (wrEnPri)  enPriFf  <= sfrWrData & MASK_EN_PRI;
      if (wrPrioLo) prioLoFf <= sfrWrData & MASK_PRIO;
      if (wrEnSec)  enSecFf  <= sfrWrData & MASK_EN_SEC;
      if (wrPrioHi) prioHiFf <= sfrWrData & MASK_PRIO;
    end
  end

  // Flags, edge history and read data
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      flagsFf      <= RST_REQ_FLAGS;
      prevFf       <= 8'h03;      // Active-low inputs idle high, so no false fall
      pin3FlagFf   <= 1'b0;
      cipherFlagFf <= 1'b0;
      rdDataFf     <= 8'h00;
    end else begin
      flagsFf      <= nxt_flags;
      prevFf       <= curIn;
      pin3FlagFf   <= nxt_pin3Flag;
      cipherFlagFf <= nxt_cipherFlag;
      if (sfrRdEn) rdDataFf <= rdMux;
    end
  end

  // Arbitration result and service nesting
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reqFf       <= 1'b0;
      idxFf       <= 4'h0;
      lvlFf       <= 2'b00;
      vecFf       <= 16'h0000;
      inServiceFf <= 4'h0;
    end else begin
      reqFf       <= take;
      idxFf       <= winIdx;
      lvlFf       <= winLvl;
      vecFf       <= VEC_TAB[winIdx];
      inServiceFf <= nxt_inService;
    end
  end

  assign sfrRdData = rdDataFf;
  assign irqReq    = reqFf;
  assign irqVector = vecFf;

  // Checks on the block's own behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  wire [2:0] winGrp = (winIdx >= 4'd6) ? 3'(winIdx - 4'd6) : 3'(winIdx);
  wire [1:0] winLvlRaw = {prioHiFf[winGrp], prioLoFf[winGrp]};

  global_gate_a: assert property (!enPriFf[BIT_GLOBAL_EN] |=> !irqReq)
    else $error("request offered while global enable clear");
  preempt_level_a: assert property (irqReq && $past(topValid) |->
      lvlFf > $past(topLvl))
    else $error("request not above running level");
  vector_table_a: assert property (irqReq |-> irqVector == VEC_TAB[idxFf])
    else $error("vector does not match slot");
  serial_vector_a: assert property (irqReq && idxFf == SRC_SERIAL |->
      irqVector == 16'h0023)
    else $error("serial vector wrong");
  prio_decode_a: assert property (irqReq |-> lvlFf == $past(winLvlRaw))
    else $error("level decode wrong");
  auto_clear_a: assert property (ackTaken && idxFf == SRC_USB && !usbRise
      && !wrFlags |=> !flagsFf[FLG_USB])
    else $error("usb flag not cleared on vectoring");
  keep_flag_a: assert property (ackTaken && idxFf == SRC_RADIO_SPI &&
      flagsFf[FLG_RADIO_SPI] && !wrFlags |=> flagsFf[FLG_RADIO_SPI])
    else $error("radio spi flag cleared by hardware");
  wake_mark_a: assert property (wakeRise |=> flagsFf[FLG_WAKE])
    else $error("wakeup flag not set");
  spi_gate_a: assert property (spiSelFf[1:0] == 2'b00 &&
      !flagsFf[FLG_SPI_DONE] && !wrFlags |=> !flagsFf[FLG_SPI_DONE])
    else $error("spi flag set while both selects clear");
  ack_drop_a: assert property (ackTaken |=> !irqReq && inServiceFf != 4'h0)
    else $error("request not withdrawn after ack");
  // Edge-mode latches must catch even a one-cycle low pulse
  pin3_latch_a: assert property (pin3EdgeSel && pin3Fall |=> pin3FlagFf)
    else $error("pin3 falling edge not latched");
  cipher_latch_a: assert property (cipherEdgeSel && cipherFall |=> cipherFlagFf)
    else $error("cipher falling edge not latched");

  preempt_c: cover property (topValid && ackTaken ##1 inServiceFf[3] && inServiceFf[0]);
  serial_c:  cover property (irqReq && idxFf == SRC_SERIAL);
  spi_c:     cover property (irqReq && idxFf == SRC_SPI_DONE);
  retire_c:  cover property (irqRetAck && topValid);
  cipher_c:  cover property (irqReq && idxFf == SRC_CIPHER && cipherEdgeSel);

endmodule

// file: rtl/pvi_pkg.sv
// Constants shared by the prioritized vectored interrupt unit
package pvi_pkg;

  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_SPI_SEL   = 8'ha6;
  localparam logic [7:0] ADDR_EN_PRI    = 8'ha8;
  localparam logic [7:0] ADDR_PRIO_LO   = 8'ha9;
  localparam logic [7:0] ADDR_EN_SEC    = 8'hb8;
  localparam logic [7:0] ADDR_PRIO_HI   = 8'hb9;
  localparam logic [7:0] ADDR_REQ_FLAGS = 8'hc0;

  // Values after reset
  localparam logic [7:0] RST_SPI_SEL   = 8'h01;
  localparam logic [7:0] RST_EN_PRI    = 8'h00;
  localparam logic [7:0] RST_PRIO      = 8'h00;
  localparam logic [7:0] RST_EN_SEC    = 8'h00;
  localparam logic [7:0] RST_REQ_FLAGS = 8'h00;

  // Writable bits of each register; the rest read as zero
  localparam logic [7:0] MASK_SPI_SEL = 8'h03;
  localparam logic [7:0] MASK_EN_PRI  = 8'hbf;
  localparam logic [7:0] MASK_PRIO    = 8'h3f;
  localparam logic [7:0] MASK_EN_SEC  = 8'hbf;

  // Field positions
  localparam int BIT_GLOBAL_EN  = 7;
  localparam int BIT_SPI_MASTER = 1;
  localparam int BIT_SPI_SLAVE  = 0;
  localparam int FLG_T2_EXT     = 7;
  localparam int FLG_T2_OVF     = 6;
  localparam int FLG_WAKE       = 5;
  localparam int FLG_USB        = 4;
  localparam int FLG_USB_RESUME = 3;
  localparam int FLG_SPI_DONE   = 2;
  localparam int FLG_RADIO      = 1;
  localparam int FLG_RADIO_SPI  = 0;

  // Arbitration slots, in ascending vector order
  localparam int NUM_SRC        = 12;
  localparam int NUM_GRP        = 6;
  localparam int NUM_LVL        = 4;
  localparam logic [3:0] SRC_PIN3       = 4'h0;
  localparam logic [3:0] SRC_TIMER0     = 4'h1;
  localparam logic [3:0] SRC_CIPHER     = 4'h2;
  localparam logic [3:0] SRC_TIMER1     = 4'h3;
  localparam logic [3:0] SRC_SERIAL     = 4'h4;
  localparam logic [3:0] SRC_TIMER2     = 4'h5;
  localparam logic [3:0] SRC_RADIO_SPI  = 4'h6;
  localparam logic [3:0] SRC_RADIO      = 4'h7;
  localparam logic [3:0] SRC_SPI_DONE   = 4'h8;
  localparam logic [3:0] SRC_USB_RESUME = 4'h9;
  localparam logic [3:0] SRC_USB        = 4'ha;
  localparam logic [3:0] SRC_WAKE       = 4'hb;

  // Vector address of each slot
  localparam logic [15:0] VEC_TAB [NUM_SRC] = '{
    16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
    16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b
  };

endpackage

// file: testbench/pvi_core_model.sv
// Behavioural core: takes offered interrupts and signals routine returns
`timescale 1ns/1ps
module pvi_core_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Bench controls
  input  wire logic [3:0]  ackDelay,
  input  wire logic        retReq,
  // Interrupt handshake
  input  wire logic        irqReq,
  input  wire logic [15:0] irqVector,
  output logic             irqAck,
  output logic             irqRetAck,
  // What the core vectored to
  output logic      [15:0] takenVec,
  output logic      [7:0]  takenCnt
);
  logic [3:0] waitCnt_ff;

  // Ack once the offer has stood ackDelay cycles; a slow core lets the offer
  // change under it, so the vector is latched at the edge the ack is taken
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irqAck     <= 1'b0;
      irqRetAck  <= 1'b0;
      waitCnt_ff <= 4'h0;
      takenVec   <= 16'h0000;
      takenCnt   <= 8'h00;
    end else begin
      irqAck     <= irqReq && !irqAck && (waitCnt_ff >= ackDelay);
      irqRetAck  <= retReq;
      waitCnt_ff <= (irqReq && !irqAck) ? waitCnt_ff + 4'h1 : 4'h0;
      if (irqAck && irqReq) begin
        takenVec <= irqVector;
        takenCnt <= takenCnt + 8'h01;
      end
    end
  end
endmodule

// file: testbench/pvi_irq_unit_test.sv
// Self-checking bench for the prioritized vectored interrupt unit
`timescale 1ns/1ps
module pvi_irq_unit_test;
  import pvi_pkg::*;
  // Bench-driven inputs
  logic        mclk        = 1'b0;
  logic        rst_b       = 1'b0;
  logic [7:0]  sfrAddr     = 8'h00;
  logic        sfrWrEn     = 1'b0;
  logic [7:0]  sfrWrData   = 8'h00;
  logic        sfrRdEn     = 1'b0;
  logic        pin3EdgeSel = 1'b0;
  logic        cipherEdgeSel = 1'b0;
  logic [3:0]  ackDelay    = 4'h0;
  logic        retReq      = 1'b0;
  logic [14:0] src         = 15'h0000;
  // Observed values
  logic [7:0]  sfrRdData;
  logic        sfrHit;
  logic        irqReq;
  logic        irqAck;
  logic        irqRetAck;
  logic [15:0] irqVector;
  logic [15:0] takenVec;
  logic [15:0] rv;
  logic [7:0]  takenCnt;
  logic [7:0]  n;
  int          num_errors  = 0;
  int          checks      = 0;
  int          cycles      = 0;
  // Order: pin3 t0 cipher t1 rx tx t2ovf t2ext rspi radio spim spis usbres usb wake
  logic [15:0] vecTab [15] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
    16'h0023, 16'h002b, 16'h002b, 16'h0043, 16'h004b, 16'h0053, 16'h0053, 16'h005b,
    16'h0063, 16'h006b};
  // Flags still set right after vectoring while the source is held
  logic [7:0]  flagTab [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h80,
    8'h01, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00};
  logic [7:0]  regAddr [6] = '{8'ha6, 8'ha8, 8'ha9, 8'hb8, 8'hb9, 8'hc0};
  logic [7:0]  regRst  [6] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  regMask [6] = '{8'h03, 8'hbf, 8'h3f, 8'hbf, 8'h3f, 8'hff};

  // Active-low sources idle high, so bit set means the request is asserted
  pvi_irq_unit u_dut (
    .mclk(mclk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .sfrHit(sfrHit),
    .pin3EdgeSel(pin3EdgeSel), .cipherEdgeSel(cipherEdgeSel), .port0_pin3(~src[0]),
    .timer0_overflow_req(src[1]), .cipher_ready_req(~src[2]),
    .timer1_overflow_req(src[3]), .serial_receive_req(src[4]),
    .serial_transmit_req(src[5]), .timer2_overflow_req(src[6]),
    .timer2_external_event_req(src[7]), .radio_spi_ready_req(src[8]),
    .radio_event_req(src[9]), .spi_master_complete_req(src[10]),
    .spi_slave_complete_req(src[11]), .usb_resume_req(src[12]),
    .usb_event_req(src[13]), .internal_wakeup_req(src[14]), .irqReq(irqReq),
    .irqVector(irqVector), .irqAck(irqAck), .irqRetAck(irqRetAck)
  );

  pvi_core_model u_core (
    .mclk(mclk), .rst_b(rst_b), .ackDelay(ackDelay), .retReq(retReq), .irqReq(irqReq),
    .irqVector(irqVector), .irqAck(irqAck), .irqRetAck(irqRetAck),
    .takenVec(takenVec), .takenCnt(takenCnt)
  );

  // Clock and hang guard; the run needs a few hundred cycles
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      final_report();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    tick(1);
    sfrWrEn = 1'b0;
  endtask

  // Read data is registered, so it is settled just after the strobe's edge
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    tick(1);
    sfrAddr = a;
    sfrRdEn = 1'b1;
    tick(1);
    sfrRdEn = 1'b0;
    rv = {8'h00, sfrRdData};
    check(rv, {8'h00, e});
  endtask

  task automatic take(input logic [15:0] v);
    n = takenCnt;
    for (int k = 0; k < 40 && takenCnt === n; k++) begin
      tick(1);
    end
    check({8'h00, takenCnt - n}, 16'h0001);
    check(takenVec, v);
  endtask

  task automatic idle();
    n = takenCnt;
    tick(10);
    check({8'h00, takenCnt}, {8'h00, n});
  endtask

  // No trailing wait, so a request freed by the return is still seen by take
  task automatic ret();
    tick(1);
    retReq = 1'b1;
    tick(1);
    retReq = 1'b0;
  endtask

  task automatic final_report();
    $display("errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rdchk(regAddr[i], regRst[i]);
      wr(regAddr[i], 8'hff);
      rdchk(regAddr[i], regMask[i]);
      check({15'h0000, sfrHit}, 16'h0001);
      wr(regAddr[i], regRst[i]);
    end
    wr(8'ha7, 8'h55);
    rdchk(8'ha7, 8'h00);
    check({15'h0000, sfrHit}, 16'h0000);
    // Flags set with every enable clear; master completion not yet selected
    src = 15'h77c0;
    tick(3);
    rdchk(8'hc0, 8'hfb);
    src[11] = 1'b1;
    tick(3);
    rdchk(8'hc0, 8'hff);
    src = 15'h0000;
    tick(3);
    wr(8'hc0, 8'h00);
    rdchk(8'hc0, 8'h00);
    // Global enable clear holds back an enabled source
    wr(8'ha6, 8'h03);
    wr(8'hb8, 8'hbf);
    wr(8'ha8, 8'h3f);
    src[1] = 1'b1;
    idle();
    wr(8'ha8, 8'hbf);
    take(16'h000b);
    src[1] = 1'b0;
    ret();
    // Individual enables clear hold back their sources even with global on
    wr(8'ha8, 8'h80);
    wr(8'hb8, 8'h00);
    src[1] = 1'b1;
    src[13] = 1'b1;
    idle();
    src = 15'h0000;
    wr(8'hc0, 8'h00);
    wr(8'ha8, 8'hbf);
    wr(8'hb8, 8'hbf);
    // Each source alone; the either-edge ones fire again on the fall
    for (int i = 0; i < 15; i++) begin
      src[i] = 1'b1;
      take(vecTab[i]);
      rdchk(8'hc0, flagTab[i]);
      if (i < 9 || i > 11)
        src[i] = 1'b0;
      wr(8'hc0, 8'h00);
      ret();
      if (i >= 9 && i <= 11) begin
        src[i] = 1'b0;
        take(vecTab[i]);
        wr(8'hc0, 8'h00);
        ret();
      end
    end
    // One-cycle low pulse on pin3 is caught in edge mode
    pin3EdgeSel = 1'b1;
    src[0] = 1'b1;
    tick(1);
    src[0] = 1'b0;
    take(16'h0003);
    ret();
    // Same for the cipher source in edge mode
    cipherEdgeSel = 1'b1;
    src[2] = 1'b1;
    tick(1);
    src[2] = 1'b0;
    take(16'h0013);
    ret();
    // Equal levels go to the lower vector first
    src[3] = 1'b1;
    src[1] = 1'b1;
    take(16'h000b);
    src[1] = 1'b0;
    ret();
    take(16'h001b);
    src[3] = 1'b0;
    ret();
    // Levels: t1 at 1, t0 and serial at 2, timer2 at 3; slow core
    ackDelay = 4'h3;
    wr(8'ha9, 8'h28);
    wr(8'hb9, 8'h32);
    src[3] = 1'b1;
    take(16'h001b);
    src[1] = 1'b1;
    take(16'h000b);
    src[4] = 1'b1;
    idle();
    src[1] = 1'b0;
    ret();
    take(16'h0023);
    src[6] = 1'b1;
    take(16'h002b);
    src[6] = 1'b0;
    wr(8'hc0, 8'h00);
    ret();
    src[4] = 1'b0;
    ret();
    src[3] = 1'b0;
    ret();
    idle();
    final_report();
  end
endmodule
